/* pdc_cap_ctrl_regs.sv */
// Device capabilities and device control register bank behind AXI4-Lite
//
// Notes on behaviour
// - Supported payload resets 001b, or 010b with the 512 strap; autoload may override.
// - Phantom function support always reads 00b.
// - Extended tag support bit always reads zero.
// - Both endpoint acceptable latency fields read 000b.
// - Role-based error reporting bit resets to one; autoload may change it.
// - Upstream port captures slot power value from the message; else 00h.
// - Upstream port captures slot power scale from the message; else 00b.
// - Four writable error reporting enables, reset zero, gate reporting per class.
// - Relaxed ordering and no snoop enables read zero, not writable.
// - Writable payload size, reset 000b, clamped to the supported value.
// - Extended tag and phantom function enables read zero whatever is written.
// - Aux power enable is a sticky writable bit, reset zero.
// - Read request size field hardwired to 000b.
// - Error detected flags set on every error regardless of enables.
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/10ps
module pdc_cap_ctrl_regs (
  // Clock and resets
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic porReset_n,
  // Straps and port role
  input wire logic payload_512_strap,
  input wire logic isUpstream,
  // Autoload of defaults
  input wire logic loadValid,
  input wire logic [2:0] loadMpsSupported,
  input wire logic loadRoleErr,
  // Slot power limit message
  input wire logic slotPwrMsgValid,
  input wire logic [7:0] slotPwrMsgValue,
  input wire logic [1:0] slotPwrMsgScale,
  // Error events and aux power
  input wire logic [3:0] errEvent,
  input wire logic auxPwrDetected,
  // AXI4-Lite
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Control outputs
  output logic [2:0] maxPayloadSupported,
  output logic [2:0] maxPayloadSize,
  output logic [3:0] errReportEnable,
  output logic auxPmEnable,
  output logic [3:0] errMsgReq,
  output logic [7:0] slotPwrValue,
  output logic [1:0] slotPwrScale
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  logic wrEn;
  logic [7:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  logic [7:0] rdAddr;
  logic [31:0] rdData;
  logic wrHit;
  logic rdHit;
  logic [2:0] mpsSup_r, mpsSup_nxt;
  logic roleErr_r, roleErr_nxt;
  logic strapDone_r;
  logic [7:0] splVal_r, splVal_nxt;
  logic [1:0] splScale_r, splScale_nxt;
  logic [3:0] errEn_r, errEn_nxt;
  logic [2:0] mps_r, mps_nxt;
  logic auxPm_r, auxPm_nxt;
  logic [3:0] errDetected;
  logic [3:0] stsClr;
  logic [2:0] mpsWrite;
  logic [2:0] mpsClamped;
  logic [2:0] strapDefault;
  logic [31:0] capWord;
  logic [31:0] ctrlWord;

  ////////////////////////////////////////////////////////////////////////
  // Bus front end

  pdc_axil_slave u_slave (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wrEn(wrEn),
    .wrAddr(wrAddr),
    .wrData(wrData),
    .wrStrb(wrStrb),
    .wrHit(wrHit),
    .rdAddr(rdAddr),
    .rdData(rdData),
    .rdHit(rdHit)
  );

  ////////////////////////////////////////////////////////////////////////
  // Address decode

  // Word compare; the low address bits are ignored
  wire wrCap = ({wrAddr[7:2], 2'b00} == pdc_pkg::CAP_OFFSET);
  wire wrCtrl = ({wrAddr[7:2], 2'b00} == pdc_pkg::CTRL_OFFSET);
  wire rdCap = ({rdAddr[7:2], 2'b00} == pdc_pkg::CAP_OFFSET);
  wire rdCtrl = ({rdAddr[7:2], 2'b00} == pdc_pkg::CTRL_OFFSET);
  wire ctrlWrLo = wrEn && wrCtrl && wrStrb[0];
  wire ctrlWrHi = wrEn && wrCtrl && wrStrb[1];
  wire stsWr = wrEn && wrCtrl && wrStrb[2];

  // Capability writes are accepted and dropped, so they still answer OKAY
  assign wrHit = wrCap || wrCtrl;
  assign rdHit = rdCap || rdCtrl;

  ////////////////////////////////////////////////////////////////////////
  // Capability defaults: strap, then autoload

  // Strap is caught on the first edge after release, never under reset
  assign strapDefault = payload_512_strap ? pdc_pkg::MPS_SUP_STRAP1
                                          : pdc_pkg::MPS_SUP_STRAP0;

  // Autoload wins over the strap when both land in one cycle
  always_comb
  begin
    mpsSup_nxt = mpsSup_r;
    roleErr_nxt = roleErr_r;
    if (!strapDone_r)
    begin
      mpsSup_nxt = strapDefault;
    end
    if (loadValid)
    begin
      mpsSup_nxt = loadMpsSupported;
      roleErr_nxt = loadRoleErr;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      strapDone_r <= 1'b0;
      mpsSup_r <= pdc_pkg::MPS_SUP_STRAP0;
      roleErr_r <= pdc_pkg::ROLE_ERR_RST;
    end
    else
    begin
      strapDone_r <= 1'b1;
      mpsSup_r <= mpsSup_nxt;
      roleErr_r <= roleErr_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Captured slot power limit

  // Downstream ports never capture, and drop a held value if the role changes
  always_comb
  begin
    splVal_nxt = splVal_r;
    splScale_nxt = splScale_r;
    if (!isUpstream)
    begin
      splVal_nxt = pdc_pkg::SPL_VAL_RST;
      splScale_nxt = pdc_pkg::SPL_SCALE_RST;
    end
    else if (slotPwrMsgValid)
    begin
      splVal_nxt = slotPwrMsgValue;
      splScale_nxt = slotPwrMsgScale;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      splVal_r <= pdc_pkg::SPL_VAL_RST;
      splScale_r <= pdc_pkg::SPL_SCALE_RST;
    end
    else
    begin
      splVal_r <= splVal_nxt;
      splScale_r <= splScale_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Device control

  // Clamp so software can never exceed what the port supports
  assign mpsWrite = wrData[pdc_pkg::CTRL_MPS_LSB +: pdc_pkg::MPS_W];
  assign mpsClamped = (mpsWrite > mpsSup_nxt) ? mpsSup_nxt : mpsWrite;

  // Only enables, payload size and aux enable hold state
  always_comb
  begin
    errEn_nxt = errEn_r;
    mps_nxt = mps_r;
    if (ctrlWrLo)
    begin
      errEn_nxt = wrData[pdc_pkg::CTRL_ERR_EN_LSB +: pdc_pkg::ERR_W];
      mps_nxt = mpsClamped;
    end
    else if (mps_r > mpsSup_nxt)
    begin
      mps_nxt = mpsSup_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      errEn_r <= pdc_pkg::ERR_EN_RST;
      mps_r <= pdc_pkg::MPS_RST;
    end
    else
    begin
      errEn_r <= errEn_nxt;
      mps_r <= mps_nxt;
    end
  end

  // Sticky bit: only power-on clears it, a function reset leaves it alone
  assign auxPm_nxt = ctrlWrHi ? wrData[pdc_pkg::CTRL_AUX_PM_BIT] : auxPm_r;

  always_ff @(posedge sys_clk or negedge porReset_n)
  begin
    if (!porReset_n)
    begin
      auxPm_r <= pdc_pkg::AUX_PM_RST;
    end
    else
    begin
      auxPm_r <= auxPm_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Device status error flags

  // Write one to clear, on the third byte lane only
  assign stsClr = stsWr ? wrData[pdc_pkg::STS_ERR_DET_LSB +: pdc_pkg::ERR_W] : 4'h0;

  pdc_err_status #(
    .ERR_W(pdc_pkg::ERR_W)
  ) u_status (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .errEvent(errEvent),
    .errEnable(errEn_r),
    .clrMask(stsClr),
    .errDetected(errDetected),
    .errMsgReq(errMsgReq)
  );

  ////////////////////////////////////////////////////////////////////////
  // Read data

  // Unlisted bits stay zero: hardwired fields and reserved space alike
  assign capWord = ({29'h0, mpsSup_r} << pdc_pkg::CAP_MPS_LSB)
                 | ({31'h0, roleErr_r} << pdc_pkg::CAP_ROLE_ERR_BIT)
                 | ({24'h0, splVal_r} << pdc_pkg::CAP_SPL_VAL_LSB)
                 | ({30'h0, splScale_r} << pdc_pkg::CAP_SPL_SCALE_LSB);

  // Bits 4, 8, 9, 11 and 14:12 have no storage and read zero
  assign ctrlWord = ({28'h0, errEn_r} << pdc_pkg::CTRL_ERR_EN_LSB)
                  | ({29'h0, mps_r} << pdc_pkg::CTRL_MPS_LSB)
                  | ({31'h0, auxPm_r} << pdc_pkg::CTRL_AUX_PM_BIT)
                  | ({28'h0, errDetected} << pdc_pkg::STS_ERR_DET_LSB)
                  | ({31'h0, auxPwrDetected} << pdc_pkg::STS_AUX_DET_BIT);

  assign rdData = rdCap ? capWord : (rdCtrl ? ctrlWord : 32'h0000_0000);

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign maxPayloadSupported = mpsSup_r;
  assign maxPayloadSize = mps_r;
  assign errReportEnable = errEn_r;
  assign auxPmEnable = auxPm_r;
  assign slotPwrValue = splVal_r;
  assign slotPwrScale = splScale_r;

endmodule : pdc_cap_ctrl_regs

/* pdc_pkg.sv */
// Shared constants for the device capability and control register bank
package pdc_pkg;

  // Register byte offsets
  localparam logic [7:0] CAP_OFFSET = 8'hc4;
  localparam logic [7:0] CTRL_OFFSET = 8'hc8;

  // Capability field positions
  localparam int CAP_MPS_LSB = 0;
  localparam int CAP_ROLE_ERR_BIT = 15;
  localparam int CAP_SPL_VAL_LSB = 18;
  localparam int CAP_SPL_SCALE_LSB = 26;

  // Control and status field positions
  localparam int CTRL_ERR_EN_LSB = 0;
  localparam int CTRL_MPS_LSB = 5;
  localparam int CTRL_AUX_PM_BIT = 10;
  localparam int STS_ERR_DET_LSB = 16;
  localparam int STS_AUX_DET_BIT = 20;

  // Field widths
  localparam int MPS_W = 3;
  localparam int ERR_W = 4;
  localparam int SPL_VAL_W = 8;
  localparam int SPL_SCALE_W = 2;

  // Reset values
  localparam logic [2:0] MPS_SUP_STRAP0 = 3'h1;
  localparam logic [2:0] MPS_SUP_STRAP1 = 3'h2;
  localparam logic ROLE_ERR_RST = 1'b1;
  localparam logic [2:0] MPS_RST = 3'h0;
  localparam logic [3:0] ERR_EN_RST = 4'h0;
  localparam logic [7:0] SPL_VAL_RST = 8'h00;
  localparam logic [1:0] SPL_SCALE_RST = 2'h0;
  localparam logic AUX_PM_RST = 1'b0;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Write path states
  typedef enum logic [1:0] {
    WR_COLLECT = 2'b00,
    WR_COMMIT = 2'b01,
    WR_RESP = 2'b10
  } pdc_wr_state_t;

endpackage : pdc_pkg

/* pdc_axil_slave.sv */
// AXI4-Lite slave front end producing a write strobe and a read address
`timescale 1ns/10ps
module pdc_axil_slave (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // AXI4-Lite
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Register side
  output logic wrEn,
  output logic [7:0] wrAddr,
  output logic [31:0] wrData,
  output logic [3:0] wrStrb,
  input wire logic wrHit,
  output logic [7:0] rdAddr,
  input wire logic [31:0] rdData,
  input wire logic rdHit
);

  pdc_pkg::pdc_wr_state_t state_r, state_nxt;
  logic awHeld_r, wHeld_r, bothHeld;
  logic [7:0] awAddr_r;
  logic [31:0] wData_r, rData_r;
  logic [3:0] wStrb_r;
  logic [1:0] bResp_r, rResp_r;
  logic rValid_r;
  wire awTake = s_axi_awvalid && s_axi_awready;
  wire wTake = s_axi_wvalid && s_axi_wready;
  wire arTake = s_axi_arvalid && s_axi_arready;

  // Handshakes and register-side view
  assign s_axi_awready = (state_r == pdc_pkg::WR_COLLECT) && !awHeld_r;
  assign s_axi_wready = (state_r == pdc_pkg::WR_COLLECT) && !wHeld_r;
  assign s_axi_bvalid = (state_r == pdc_pkg::WR_RESP);
  assign s_axi_bresp = bResp_r;
  assign s_axi_arready = !rValid_r;
  assign s_axi_rvalid = rValid_r;
  assign s_axi_rdata = rData_r;
  assign s_axi_rresp = rResp_r;
  assign bothHeld = (awHeld_r || awTake) && (wHeld_r || wTake);
  assign wrEn = (state_r == pdc_pkg::WR_COMMIT);
  assign wrAddr = awAddr_r;
  assign wrData = wData_r;
  assign wrStrb = wStrb_r;
  assign rdAddr = s_axi_araddr;

  // Write sequencing: address and data may come in either order
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      pdc_pkg::WR_COLLECT: if (bothHeld) state_nxt = pdc_pkg::WR_COMMIT;
      pdc_pkg::WR_COMMIT: state_nxt = pdc_pkg::WR_RESP;
      pdc_pkg::WR_RESP: if (s_axi_bready) state_nxt = pdc_pkg::WR_COLLECT;
      default: state_nxt = pdc_pkg::WR_COLLECT;
    endcase
  end

  // Write channel storage
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= pdc_pkg::WR_COLLECT;
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= 8'h00;
      wData_r <= 32'h0000_0000;
      wStrb_r <= 4'h0;
      bResp_r <= pdc_pkg::RESP_OKAY;
    end
    else
    begin
      state_r <= state_nxt;
      if (awTake) awAddr_r <= s_axi_awaddr;
      if (wTake) wData_r <= s_axi_wdata;
      if (wTake) wStrb_r <= s_axi_wstrb;
      awHeld_r <= wrEn ? 1'b0 : (awHeld_r || awTake);
      wHeld_r <= wrEn ? 1'b0 : (wHeld_r || wTake);
      if (wrEn) bResp_r <= wrHit ? pdc_pkg::RESP_OKAY : pdc_pkg::RESP_DECERR;
    end
  end

  // Read channel: data sampled at the address handshake
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rValid_r <= 1'b0;
      rData_r <= 32'h0000_0000;
      rResp_r <= pdc_pkg::RESP_OKAY;
    end
    else if (arTake)
    begin
      rValid_r <= 1'b1;
      rData_r <= rdData;
      rResp_r <= rdHit ? pdc_pkg::RESP_OKAY : pdc_pkg::RESP_DECERR;
    end
    else if (s_axi_rready) rValid_r <= 1'b0;
  end

endmodule : pdc_axil_slave

/* pdc_err_status.sv */
// Error detected flags and gated error message requests
`timescale 1ns/10ps
module pdc_err_status #(
  parameter int ERR_W = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Events and control
  input wire logic [ERR_W-1:0] errEvent,
  input wire logic [ERR_W-1:0] errEnable,
  input wire logic [ERR_W-1:0] clrMask,
  // State
  output logic [ERR_W-1:0] errDetected,
  output logic [ERR_W-1:0] errMsgReq
);

  logic [ERR_W-1:0] det_r, msg_r;

  assign errDetected = det_r;
  assign errMsgReq = msg_r;

  // One flag per error class; a new event beats a clear
  for (genvar i = 0; i < ERR_W; i++)
  begin : g_flag
    wire flag_nxt = (det_r[i] && !clrMask[i]) || errEvent[i];
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
      if (!reset_n)
      begin
        det_r[i] <= 1'b0;
        msg_r[i] <= 1'b0;
      end
      else
      begin
        det_r[i] <= flag_nxt;
        msg_r[i] <= errEvent[i] && errEnable[i];
      end
    end
  end

endmodule : pdc_err_status

/* pdc_rc_model.sv */
// Root complex side: slot power messages and error events
`timescale 1ns/10ps
module pdc_rc_model (
  // Clock
  input wire logic sys_clk,
  // Message and error lines
  output logic slotPwrMsgValid,
  output logic [7:0] slotPwrMsgValue,
  output logic [1:0] slotPwrMsgScale,
  output logic [3:0] errEvent
);
  // Quiet lines from time zero
  initial
  begin
    slotPwrMsgValid = 1'b0;
    slotPwrMsgValue = 8'h00;
    slotPwrMsgScale = 2'h0;
    errEvent = 4'h0;
  end
  // One message; payload inverted after so a stale value never matches
  task automatic send_power(input logic [7:0] v, input logic [1:0] s);
    @(posedge sys_clk);
    slotPwrMsgValid <= 1'b1;
    slotPwrMsgValue <= v;
    slotPwrMsgScale <= s;
    @(posedge sys_clk);
    slotPwrMsgValid <= 1'b0;
    slotPwrMsgValue <= ~v;
    slotPwrMsgScale <= ~s;
  endtask : send_power
  // One-cycle error pulses
  task automatic send_error(input logic [3:0] e);
    @(posedge sys_clk);
    errEvent <= e;
    @(posedge sys_clk);
    errEvent <= 4'h0;
  endtask : send_error
endmodule : pdc_rc_model

/* pdc_cap_ctrl_asserts.sv */
// Concurrent checks on the capability and control bank
`timescale 1ns/10ps
module pdc_cap_ctrl_asserts (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  // Side signals
  input wire logic isUpstream,
  input wire logic slotPwrMsgValid,
  input wire logic [7:0] slotPwrMsgValue,
  input wire logic [1:0] slotPwrMsgScale,
  input wire logic [3:0] errEvent,
  input wire logic [2:0] maxPayloadSupported,
  input wire logic [2:0] maxPayloadSize,
  input wire logic [3:0] errReportEnable,
  input wire logic [3:0] errMsgReq,
  input wire logic [7:0] slotPwrValue,
  input wire logic [1:0] slotPwrScale
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////
  // Address of the read being answered
  logic [7:0] rdAddr_r;
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      rdAddr_r <= 8'h00;
    else if (s_axi_arvalid && s_axi_arready)
      rdAddr_r <= s_axi_araddr;
  end
  // Low address bits ignored, as the slave does
  wire capRd = s_axi_rvalid && rdAddr_r[7:2] == pdc_pkg::CAP_OFFSET[7:2];
  wire ctlRd = s_axi_rvalid && rdAddr_r[7:2] == pdc_pkg::CTRL_OFFSET[7:2];
  sequence wrTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  ////////////////////////////////////////
  wr_answer_a: assert property (wrTaken |-> ##[1:3] s_axi_bvalid)
    else $error("write not answered");
  cap_fixed_a: assert property (capRd |-> s_axi_rdata[31:28] == 4'h0 &&
    s_axi_rdata[17:16] == 2'h0 && s_axi_rdata[14:3] == 12'h000) else $error("cap fixed bits");
  cap_live_a: assert property ($rose(s_axi_rvalid) && capRd |->
    s_axi_rdata[2:0] == $past(maxPayloadSupported) &&
    s_axi_rdata[27:18] == {$past(slotPwrScale), $past(slotPwrValue)}) else $error("cap fields");
  ctl_fixed_a: assert property (ctlRd |-> s_axi_rdata[4] == 1'b0 && s_axi_rdata[9:8] == 2'h0 &&
    s_axi_rdata[15:11] == 5'h00 && s_axi_rdata[31:21] == 11'h000) else $error("ctrl fixed bits");
  unmapped_a: assert property (s_axi_rvalid && !capRd && !ctlRd |->
    s_axi_rresp == pdc_pkg::RESP_DECERR && s_axi_rdata == 32'h0) else $error("unmapped read");
  mps_clamp_a: assert property ($stable(maxPayloadSupported) |->
    maxPayloadSize <= maxPayloadSupported) else $error("payload not clamped");
  err_gate_a: assert property (errMsgReq == ($past(errEvent) & $past(errReportEnable)))
    else $error("error report gating");
  slot_clear_a: assert property (!isUpstream |=> slotPwrValue == 8'h00 && slotPwrScale == 2'h0)
    else $error("slot power not cleared");
  slot_take_a: assert property (slotPwrMsgValid && isUpstream |=>
    slotPwrValue == $past(slotPwrMsgValue) && slotPwrScale == $past(slotPwrMsgScale))
    else $error("slot power not captured");
endmodule : pdc_cap_ctrl_asserts
////////////////////////////////////////
bind pdc_cap_ctrl_regs pdc_cap_ctrl_asserts u_asserts (.sys_clk, .reset_n, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .isUpstream, .slotPwrMsgValid, .slotPwrMsgValue, .slotPwrMsgScale, .errEvent,
  .maxPayloadSupported, .maxPayloadSize, .errReportEnable, .errMsgReq, .slotPwrValue, .slotPwrScale);

/* pcie_device_cap_ctrl_regs_test.sv */
// Self-checking bench for the capability and control bank
`timescale 1ns/10ps
module pcie_device_cap_ctrl_regs_test;
  // Design signals
  logic sys_clk, reset_n, porReset_n, payload_512_strap, isUpstream, loadValid, loadRoleErr, auxPwrDetected;
  logic [2:0] loadMpsSupported, maxPayloadSupported, maxPayloadSize;
  logic slotPwrMsgValid, auxPmEnable;
  logic [7:0] slotPwrMsgValue, slotPwrValue, s_axi_awaddr, s_axi_araddr;
  logic [1:0] slotPwrMsgScale, slotPwrScale, s_axi_bresp, s_axi_rresp, rs;
  logic [3:0] errEvent, errReportEnable, errMsgReq, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, wd;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  // Reference model state and counters
  int err_count, comparisons, mSup, mRole, mMps, mEn, mAux, mDet, mSv, mSs, i;

  pdc_cap_ctrl_regs DUT (.sys_clk, .reset_n, .porReset_n, .payload_512_strap, .isUpstream, .loadValid,
    .loadMpsSupported, .loadRoleErr, .slotPwrMsgValid, .slotPwrMsgValue, .slotPwrMsgScale, .errEvent,
    .auxPwrDetected, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .maxPayloadSupported, .maxPayloadSize, .errReportEnable, .auxPmEnable, .errMsgReq,
    .slotPwrValue, .slotPwrScale);
  pdc_rc_model u_rc (.sys_clk, .slotPwrMsgValid, .slotPwrMsgValue, .slotPwrMsgScale, .errEvent);

  // 25 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////
  // Expected register words
  function automatic logic [31:0] capExp();
    return 32'(mSup) | 32'(mRole) << 15 | 32'(mSv) << 18 | 32'(mSs) << 26;
  endfunction : capExp
  function automatic logic [31:0] ctlExp();
    return 32'(mEn) | 32'(mMps) << 5 | 32'(mAux) << 10 | 32'(mDet) << 16 | 32'(auxPwrDetected) << 20;
  endfunction : ctlExp
  // Function reset leaves the sticky aux enable alone
  function automatic void modelReset();
    mSup = payload_512_strap ? 2 : 1;
    mRole = 1;
    {mMps, mEn, mDet, mSv, mSs} = '0;
  endfunction : modelReset
  // Control write by byte lane; status lane is write-one-to-clear
  function automatic void ctlWrite(logic [31:0] d, logic [3:0] s);
    if (s[0])
    begin
      mEn = d[3:0];
      mMps = d[7:5] > mSup ? mSup : d[7:5];
    end
    if (s[1])
      mAux = d[10];
    if (s[2])
      mDet = mDet & ~d[19:16];
  endfunction : ctlWrite
  ////////////////////////////////////////
  task automatic chk_data(string what, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_data
  task automatic chk_resp(string what, logic [1:0] exp, logic [1:0] got);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_resp
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out
  task automatic timed_out();
    err_count++;
    $display("MISMATCH bus answer expected in time seen none");
    close_out();
  endtask : timed_out
  ////////////////////////////////////////
  // Ready sampled at the falling edge, so release lands right after the taking edge
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    int n;
    logic ta, tw, done;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    done = 1'b0;
    for (n = 0; n < 40 && !done; n++)
    begin
      @(negedge sys_clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      done = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge sys_clk);
      if (ta)
        s_axi_awvalid <= 1'b0;
      if (tw)
        s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    if (!done)
      timed_out();
  endtask : axi_write
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ta, done;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    done = 1'b0;
    for (n = 0; n < 40 && !done; n++)
    begin
      @(negedge sys_clk);
      ta = s_axi_arvalid && s_axi_arready;
      done = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge sys_clk);
      if (ta)
        s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    if (!done)
      timed_out();
  endtask : axi_read
  task automatic check_reg(input logic [7:0] a, input logic [31:0] exp);
    axi_read(a, rd, rs);
    chk_resp("read resp", pdc_pkg::RESP_OKAY, rs);
    chk_data("read data", exp, rd);
  endtask : check_reg
  ////////////////////////////////////////
  // Main sequence
  initial
  begin
    {reset_n, porReset_n, loadValid, loadRoleErr, loadMpsSupported} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {payload_512_strap, isUpstream, auxPwrDetected} = 3'h7;
    {err_count, comparisons, mAux} = '0;
    i = $urandom(38);
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    porReset_n <= 1'b1;
    modelReset();
    repeat (2) @(posedge sys_clk);
    check_reg(pdc_pkg::CAP_OFFSET, capExp());
    check_reg(pdc_pkg::CTRL_OFFSET, ctlExp());
    // Every payload code with random enables and ignored bits
    for (i = 0; i < 8; i++)
    begin
      wd = $urandom;
      wd[7:5] = i[2:0];
      axi_write(pdc_pkg::CTRL_OFFSET, wd, 4'h3, rs);
      ctlWrite(wd, 4'h3);
      check_reg(pdc_pkg::CTRL_OFFSET, ctlExp());
    end
    // Flags set whatever the enables, then cleared by ones
    for (i = 0; i < 4; i++)
    begin
      wd = $urandom;
      auxPwrDetected <= wd[20];
      u_rc.send_error(wd[3:0]);
      mDet = mDet | wd[3:0];
      check_reg(pdc_pkg::CTRL_OFFSET, ctlExp());
      axi_write(pdc_pkg::CTRL_OFFSET, wd, 4'h4, rs);
      ctlWrite(wd, 4'h4);
      check_reg(pdc_pkg::CTRL_OFFSET, ctlExp());
    end
    // Slot power taken upstream only
    wd = $urandom;
    u_rc.send_power(wd[7:0], wd[9:8]);
    {mSv, mSs} = {24'h0, wd[7:0], 30'h0, wd[9:8]};
    check_reg(pdc_pkg::CAP_OFFSET, capExp());
    isUpstream <= 1'b0;
    u_rc.send_power(~wd[7:0], wd[9:8]);
    {mSv, mSs} = '0;
    check_reg(pdc_pkg::CAP_OFFSET, capExp());
    isUpstream <= 1'b1;
    // Autoload lowers the supported size under the programmed one
    axi_write(pdc_pkg::CTRL_OFFSET, 32'h000000e0, 4'h1, rs);
    ctlWrite(32'h000000e0, 4'h1);
    {loadValid, loadMpsSupported, loadRoleErr} <= 5'b1_001_0;
    @(posedge sys_clk);
    loadValid <= 1'b0;
    {mSup, mRole, mMps} = {32'd1, 32'd0, 32'd1};
    check_reg(pdc_pkg::CAP_OFFSET, capExp());
    check_reg(pdc_pkg::CTRL_OFFSET, ctlExp());
    // Read-only and unmapped places
    axi_write(pdc_pkg::CAP_OFFSET, 32'hffffffff, 4'hf, rs);
    chk_resp("write resp", pdc_pkg::RESP_OKAY, rs);
    check_reg(pdc_pkg::CAP_OFFSET, capExp());
    axi_write(8'h10, 32'hffffffff, 4'hf, rs);
    chk_resp("write resp", pdc_pkg::RESP_DECERR, rs);
    axi_read(8'h10, rd, rs);
    chk_resp("read resp", pdc_pkg::RESP_DECERR, rs);
    chk_data("read data", 32'h0, rd);
    // Function reset keeps aux enable; power-on reset clears it
    axi_write(pdc_pkg::CTRL_OFFSET, 32'h00000400, 4'h2, rs);
    ctlWrite(32'h00000400, 4'h2);
    reset_n <= 1'b0;
    payload_512_strap <= 1'b0;
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    modelReset();
    check_reg(pdc_pkg::CAP_OFFSET, capExp());
    check_reg(pdc_pkg::CTRL_OFFSET, ctlExp());
    porReset_n <= 1'b0;
    @(posedge sys_clk);
    porReset_n <= 1'b1;
    mAux = 0;
    check_reg(pdc_pkg::CTRL_OFFSET, ctlExp());
    chk_data("aux enable", 32'(mAux), 32'(auxPmEnable));
    close_out();
  end
endmodule : pcie_device_cap_ctrl_regs_test
